/* File: hdl/link_control_register.sv */
// link operation control register with its receive filter and transmit gating
// assumes receiver, transmitter, bus-reset logic and host port share clock_i
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "link_ctrl_map.svh"

module link_control_register
    import link_ctrl_pkg::*;
#(
    parameter int ADDR_W = `LC_ADDR_W,
    parameter int DATA_W = `LC_DATA_W
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // host register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rd_data_o,
    // bus reset from the bus-reset logic
    input wire logic bus_reset_i,
    // node address from the node-address register
    input wire logic [15:0] node_address_i,
    // receiver packet stream
    input wire logic rx_start_i,
    input wire pkt_kind_t rx_kind_i,
    input wire logic [15:0] rx_dest_id_i,
    input wire logic rx_quad_valid_i,
    input wire logic [31:0] rx_quad_i,
    input wire logic rx_end_i,
    // acknowledge to the receiver
    output logic ack_busy_o,
    // general receive fifo write side
    input wire logic grf_full_i,
    output logic grf_wr_o,
    output logic [31:0] grf_data_o,
    // transmitter arbitration
    input wire logic async_tx_req_i,
    input wire logic iso_tx_req_i,
    output logic async_arb_req_o,
    output logic iso_arb_req_o
);

    // receive sequencing states
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_STORE,
        RX_DROP,
        RX_STATUS
    } rx_state_t;

    // register state
    logic [31:0] ctrl_reg;
    logic [DATA_W-1:0] rd_data_reg;

    // receive state
    rx_state_t rx_state_reg;
    rx_state_t rx_state_next;
    pkt_kind_t pkt_kind_reg;
    logic first_only_reg;
    logic busy_pkt_reg;
    logic [`LC_QUAD_IDX_W-1:0] quad_idx_reg;
    logic grf_wr_reg;
    logic [31:0] grf_data_reg;
    logic ack_busy_reg;

    // transmit state
    logic async_arb_reg;
    logic iso_arb_reg;

    // filter verdict for the announced packet
    logic accept;
    logic busy;
    logic first_only;
    logic [3:0] selfid_status;
    logic selfid_clear;
    logic ctrl_hit;
    logic store_quad;
    logic rx_take;
    logic async_tx_enable;
    logic iso_tx_enable;

    // decode of the control register address
    assign ctrl_hit = addr_i == ADDR_W'(`LC_LINK_OPERATION_CONTROL_OFS);

    // field views of the transmit enables
    assign async_tx_enable = ctrl_reg[`LC_ASYNC_TRANSMIT_ENABLE_POS];
    assign iso_tx_enable = ctrl_reg[`LC_ISO_TRANSMIT_ENABLE_POS];

    // control register, bus reset drops both async enables
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `LC_LINK_OPERATION_CONTROL_RST;
        end else begin
            if (wr_i && ctrl_hit) begin
                ctrl_reg <= wr_data_i[31:0] & `LC_CTRL_WRITE_MASK;
            end
            if (bus_reset_i) begin
                ctrl_reg[`LC_ASYNC_TRANSMIT_ENABLE_POS] <= 1'b0;
                ctrl_reg[`LC_ASYNC_RECEIVE_ENABLE_POS] <= 1'b0;
            end
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_reg <= '0;
        end else if (rd_i && ctrl_hit) begin
            rd_data_reg <= DATA_W'(ctrl_reg);
        end else begin
            rd_data_reg <= '0;
        end
    end

    // acceptance decision on the announced header
    rx_accept_filter u_filter (
        .ctrl_i(ctrl_reg),
        .kind_i(rx_kind_i),
        .dest_id_i(rx_dest_id_i),
        .node_address_i(node_address_i),
        .grf_full_i(grf_full_i),
        .accept_o(accept),
        .busy_o(busy),
        .first_only_o(first_only)
    );

    // an announce is taken only by the idle receiver
    assign rx_take = rx_start_i && rx_state_reg == RX_IDLE;

    // self-id pairs checked while they stream in
    assign selfid_clear = rx_take && rx_kind_i == PKT_SELF_ID;

    selfid_pair_check u_selfid (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .clear_i(selfid_clear),
        .quad_valid_i(rx_quad_valid_i && rx_state_reg == RX_STORE),
        .quad_i(rx_quad_i),
        .status_o(selfid_status)
    );

    // next receive state
    always_comb begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            RX_IDLE: begin
                if (rx_start_i) begin
                    rx_state_next = accept ? RX_STORE : RX_DROP;
                end
            end
            RX_STORE: begin
                if (rx_end_i) begin
                    rx_state_next = (pkt_kind_reg == PKT_SELF_ID) ? RX_STATUS : RX_IDLE;
                end
            end
            RX_DROP: begin
                if (rx_end_i) begin
                    rx_state_next = RX_IDLE;
                end
            end
            RX_STATUS: begin
                rx_state_next = RX_IDLE;
            end
            default: begin
                rx_state_next = RX_IDLE;
            end
        endcase
    end

    // receive state register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_reg <= RX_IDLE;
        end else begin
            rx_state_reg <= rx_state_next;
        end
    end

    // packet kind latched at packet start
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pkt_kind_reg <= PKT_ASYNC;
        end else if (rx_take) begin
            pkt_kind_reg <= rx_kind_i;
        end
    end

    // link-on and config packets keep their first quadlet only
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_only_reg <= 1'b0;
        end else if (rx_take) begin
            first_only_reg <= first_only;
        end
    end

    // busy verdict frozen with the fifo level seen at the start
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_pkt_reg <= 1'b0;
        end else if (rx_take) begin
            busy_pkt_reg <= busy;
        end
    end

    // quadlet position inside the packet, saturating
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            quad_idx_reg <= '0;
        end else if (rx_state_reg == RX_IDLE) begin
            quad_idx_reg <= '0;
        end else if (rx_quad_valid_i && quad_idx_reg != '1) begin
            quad_idx_reg <= quad_idx_reg + 1'b1;
        end
    end

    // only the first quadlet of link-on and config packets
    assign store_quad = rx_quad_valid_i && rx_state_reg == RX_STORE
        && !(first_only_reg && quad_idx_reg != '0);

    // fifo write strobe: data quadlets, then the self-id status quadlet
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grf_wr_reg <= 1'b0;
        end else begin
            grf_wr_reg <= rx_state_reg == RX_STATUS || store_quad;
        end
    end

    // fifo word: stored quadlet or the self-id status code
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grf_data_reg <= 32'h00000000;
        end else if (rx_state_reg == RX_STATUS) begin
            grf_data_reg <= {28'h0000000, selfid_status};
        end else if (store_quad) begin
            grf_data_reg <= rx_quad_i;
        end
    end

    // busy acknowledge pulsed at the end of a busied packet
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_busy_reg <= 1'b0;
        end else begin
            ack_busy_reg <= rx_end_i && rx_state_reg == RX_DROP && busy_pkt_reg;
        end
    end

    // async arbitration: enable set and no bus reset in this cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            async_arb_reg <= 1'b0;
        end else begin
            async_arb_reg <= async_tx_req_i && async_tx_enable && !bus_reset_i;
        end
    end

    // iso arbitration gated by its transmit enable
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iso_arb_reg <= 1'b0;
        end else begin
            iso_arb_reg <= iso_tx_req_i && iso_tx_enable;
        end
    end

    // outputs straight from flops
    assign rd_data_o = rd_data_reg;
    assign ack_busy_o = ack_busy_reg;
    assign grf_wr_o = grf_wr_reg;
    assign grf_data_o = grf_data_reg;
    assign async_arb_req_o = async_arb_reg;
    assign iso_arb_req_o = iso_arb_reg;

endmodule

/* File: hdl/link_ctrl_map.svh */
// register offsets, field positions and codes of the link control bank
// included by the package and every design file; definitions only
`ifndef LINK_CTRL_MAP_SVH
`define LINK_CTRL_MAP_SVH

// register bus geometry
`define LC_ADDR_W 8
`define LC_DATA_W 32

// byte offset of the link operation control register
`define LC_LINK_OPERATION_CONTROL_OFS 8'h08
`define LC_LINK_OPERATION_CONTROL_RST 32'h00000000

// field positions; field n sits at vector index 31-n
`define LC_NODE_ID_VALID_POS 31
`define LC_SELF_ID_RECEIVE_POS 30
`define LC_FORCE_BUSY_ACK_POS 29
`define LC_RECEIVE_ALL_ISO_POS 28
`define LC_CYCLE_START_CAPTURE_POS 27
`define LC_ASYNC_TRANSMIT_ENABLE_POS 26
`define LC_ASYNC_RECEIVE_ENABLE_POS 25
`define LC_ISO_TRANSMIT_ENABLE_POS 24
`define LC_ISO_RECEIVE_ENABLE_POS 23

// implemented bits of the control register; the rest read as zero
`define LC_CTRL_WRITE_MASK 32'hff800000

// self-id status codes stored behind the collected self-id packet
`define LC_SELF_ID_STATUS_GOOD 4'h1
`define LC_SELF_ID_STATUS_BAD 4'hd

// broadcast addresses of the destination id
`define LC_BROADCAST_NODE 6'h3f
`define LC_BROADCAST_BUS 10'h3ff

// quadlet index width inside a received packet
`define LC_QUAD_IDX_W 4

`endif

/* File: hdl/link_ctrl_pkg.sv */
// types shared by the link control register bank
// assumes the map header is on the include path
`include "link_ctrl_map.svh"

package link_ctrl_pkg;

    // kind of packet announced by the receiver
    typedef enum logic [2:0] {
        PKT_ASYNC,
        PKT_ISO,
        PKT_CYCLE_START,
        PKT_SELF_ID,
        PKT_LINK_ON,
        PKT_PHY_CONFIG
    } pkt_kind_t;

    // destination id {bus, node} addressed to all nodes
    function automatic logic is_broadcast(input logic [15:0] id);
        return id[5:0] == `LC_BROADCAST_NODE;
    endfunction

endpackage

/* File: hdl/selfid_pair_check.sv */
// checks collected self-id quadlets in pairs, second the inverse of the first
// assumes quadlets from the receiver on the same clock
`timescale 1ns/10ps
`include "link_ctrl_map.svh"

module selfid_pair_check
    import link_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // quadlet stream
    input wire logic clear_i,
    input wire logic quad_valid_i,
    input wire logic [31:0] quad_i,
    // verdict
    output logic [3:0] status_o
);

    logic [31:0] first_reg;
    logic odd_reg;
    logic bad_reg;

    // pair tracking, a new packet clears the verdict
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_reg <= 32'h00000000;
            odd_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else if (clear_i) begin
            odd_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else if (quad_valid_i) begin
            if (!odd_reg) begin
                first_reg <= quad_i;
                odd_reg <= 1'b1;
            end else begin
                odd_reg <= 1'b0;
                if (quad_i != ~first_reg) begin
                    bad_reg <= 1'b1;
                end
            end
        end
    end

    // a dangling half pair also counts as corrupted
    assign status_o = (bad_reg || odd_reg) ? `LC_SELF_ID_STATUS_BAD : `LC_SELF_ID_STATUS_GOOD;

endmodule

/* File: hdl/rx_accept_filter.sv */
// decides acceptance and busy answer for an announced packet
// assumes all inputs are on the same clock; purely combinational
`timescale 1ns/10ps
`include "link_ctrl_map.svh"

module rx_accept_filter
    import link_ctrl_pkg::*;
(
    // control fields
    input wire logic [31:0] ctrl_i,
    // packet header
    input wire pkt_kind_t kind_i,
    input wire logic [15:0] dest_id_i,
    input wire logic [15:0] node_address_i,
    input wire logic grf_full_i,
    // decision
    output logic accept_o,
    output logic busy_o,
    output logic first_only_o
);

    logic addr_hit;
    logic own_hit;
    logic async_ok;

    // own node match, bus 3ffh standing for the local bus
    assign own_hit = (dest_id_i[5:0] == node_address_i[5:0])
        && (dest_id_i[15:6] == node_address_i[15:6] || dest_id_i[15:6] == `LC_BROADCAST_BUS);
    // broadcast always, own address only when the id is valid
    assign addr_hit = is_broadcast(dest_id_i) || (ctrl_i[`LC_NODE_ID_VALID_POS] && own_hit);
    assign async_ok = ctrl_i[`LC_ASYNC_RECEIVE_ENABLE_POS] && addr_hit;

    // per-kind acceptance and busy answer
    always_comb begin
        accept_o = 1'b0;
        busy_o = 1'b0;
        first_only_o = 1'b0;
        case (kind_i)
            PKT_ASYNC: begin
                if (async_ok && !is_broadcast(dest_id_i)) begin
                    busy_o = ctrl_i[`LC_FORCE_BUSY_ACK_POS] || grf_full_i;
                end
                accept_o = async_ok && !busy_o;
            end
            PKT_ISO: begin
                accept_o = ctrl_i[`LC_ISO_RECEIVE_ENABLE_POS] && ctrl_i[`LC_RECEIVE_ALL_ISO_POS];
            end
            PKT_CYCLE_START: begin
                accept_o = ctrl_i[`LC_CYCLE_START_CAPTURE_POS];
            end
            PKT_SELF_ID: begin
                accept_o = ctrl_i[`LC_SELF_ID_RECEIVE_POS];
            end
            PKT_LINK_ON, PKT_PHY_CONFIG: begin
                accept_o = ctrl_i[`LC_SELF_ID_RECEIVE_POS];
                first_only_o = 1'b1;
            end
            default: begin
                accept_o = 1'b0;
            end
        endcase
    end

endmodule

/* File: verif/link_control_register_chk.sv */
// port assertions of the link control register
// bound to every link_control_register instance, one clock domain
`timescale 1ns/10ps
module link_control_register_chk
    import link_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // host port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rd_data_o,
    input wire logic bus_reset_i,
    // receive side
    input wire logic rx_quad_valid_i,
    input wire logic [31:0] rx_quad_i,
    input wire logic rx_end_i,
    input wire logic ack_busy_o,
    input wire logic grf_wr_o,
    input wire logic [31:0] grf_data_o,
    // transmit side
    input wire logic async_tx_req_i,
    input wire logic iso_tx_req_i,
    input wire logic async_arb_req_o,
    input wire logic iso_arb_req_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_rd_idle_zero: assert property (!$past(rd_i) || $past(addr_i) != 8'h08 |-> rd_data_o == 32'h0)
        else $error("read data not zero outside a mapped read");
    a_rd_unused_zero: assert property (rd_data_o[22:0] == 23'h0)
        else $error("unimplemented control bits read nonzero");
    a_async_arb_gate: assert property (async_arb_req_o |-> $past(async_tx_req_i))
        else $error("async arbitration without request");
    a_bus_reset_arb: assert property (bus_reset_i |-> ##2 !async_arb_req_o)
        else $error("async arbitration survives bus reset");
    a_iso_arb_gate: assert property (iso_arb_req_o |-> $past(iso_tx_req_i))
        else $error("iso arbitration without request");
    a_busy_one_cycle: assert property (ack_busy_o |=> !ack_busy_o)
        else $error("busy ack longer than one cycle");
    a_busy_after_end: assert property (ack_busy_o |-> $past(rx_end_i))
        else $error("busy ack not one cycle after packet end");
    a_store_follows_quad: assert property (grf_wr_o |-> $past(rx_quad_valid_i) || $past(rx_end_i, 2))
        else $error("fifo write without a quadlet");
    a_store_echo: assert property (grf_wr_o && $past(rx_quad_valid_i) |-> grf_data_o == $past(rx_quad_i))
        else $error("stored word differs from quadlet");
    a_status_code: assert property (grf_wr_o && !$past(rx_quad_valid_i) |-> grf_data_o inside {32'h1, 32'hd})
        else $error("self-id status word not a legal code");
endmodule

bind link_control_register link_control_register_chk #(.ADDR_W(ADDR_W)) chk_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .bus_reset_i(bus_reset_i), .rx_quad_valid_i(rx_quad_valid_i), .rx_quad_i(rx_quad_i),
    .rx_end_i(rx_end_i), .ack_busy_o(ack_busy_o), .grf_wr_o(grf_wr_o), .grf_data_o(grf_data_o),
    .async_tx_req_i(async_tx_req_i), .iso_tx_req_i(iso_tx_req_i),
    .async_arb_req_o(async_arb_req_o), .iso_arb_req_o(iso_arb_req_o));

/* File: verif/phy_fifo_side.sv */
// receive fifo and phy side model: counts stored words and busy acks
// assumes one-cycle write and ack pulses on the same clock
`timescale 1ns/10ps
module phy_fifo_side #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // drain, writes and acks
    input wire logic clr_i,
    input wire logic wr_i,
    input wire logic [31:0] data_i,
    input wire logic busy_i,
    // state seen by the bench
    output logic full_o,
    output int words_o,
    output int busy_o,
    output logic [31:0] last_o
);
    // fifo reports no room once DEPTH words wait
    assign full_o = words_o >= DEPTH;

    // word counter emptied by a software drain, busy count kept
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            words_o <= 0;
            busy_o <= 0;
            last_o <= 32'h0;
        end else begin
            words_o <= clr_i ? 0 : words_o + int'(wr_i);
            busy_o <= busy_o + int'(busy_i);
            if (wr_i) last_o <= data_i;
        end
    end
endmodule

/* File: verif/link_control_register_bench.sv */
// self-checking bench of the link control register
// drives host port, receive stream and transmit requests itself
`timescale 1ns/10ps
module link_control_register_bench;
    import link_ctrl_pkg::*;
    localparam logic [15:0] NODE = 16'h0045;
    logic clock_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, bus_reset_i = 0, fifo_clear = 0;
    logic rx_start_i = 0, rx_quad_valid_i = 0, rx_end_i = 0, async_tx_req_i = 0, iso_tx_req_i = 0;
    logic [7:0] addr_i = 0;
    logic [31:0] wr_data_i = 0, rx_quad_i = 0, rd_data_o, grf_data_o, last, ctrl, r;
    logic [15:0] rx_dest_id_i = 0;
    pkt_kind_t rx_kind_i = PKT_ASYNC;
    logic ack_busy_o, grf_wr_o, async_arb_req_o, iso_arb_req_o, grf_full_i;
    logic [15:0] dests [4] = '{16'h0045, 16'hffff, 16'h0046, 16'hffc5};
    int words, busys, exp_w = 0, exp_b = 0, miscompares = 0, checks = 0, cyc = 0, seed = 25;

    always #5 clock_i = ~clock_i;

    link_control_register uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .bus_reset_i(bus_reset_i),
        .node_address_i(NODE), .rx_start_i(rx_start_i), .rx_kind_i(rx_kind_i), .rx_dest_id_i(rx_dest_id_i),
        .rx_quad_valid_i(rx_quad_valid_i), .rx_quad_i(rx_quad_i), .rx_end_i(rx_end_i),
        .ack_busy_o(ack_busy_o), .grf_full_i(grf_full_i), .grf_wr_o(grf_wr_o), .grf_data_o(grf_data_o),
        .async_tx_req_i(async_tx_req_i), .iso_tx_req_i(iso_tx_req_i),
        .async_arb_req_o(async_arb_req_o), .iso_arb_req_o(iso_arb_req_o));
    phy_fifo_side #(.DEPTH(8)) side (.clock_i(clock_i), .rst_n_i(rst_n_i), .clr_i(fifo_clear),
        .wr_i(grf_wr_o), .data_i(grf_data_o), .busy_i(ack_busy_o), .full_o(grf_full_i),
        .words_o(words), .busy_o(busys), .last_o(last));

    // words a packet should leave in the fifo, and whether it is busied
    function automatic int exp_store(input logic [31:0] c, input pkt_kind_t k, input logic [15:0] d,
        input int n, input logic full, output logic busy);
        logic bc, acc;
        bc = d[5:0] == 6'h3f;
        busy = 0;
        case (k)
            PKT_ASYNC: begin
                acc = c[25] && (bc || c[31] && d[5:0] == 6'h05 && d[15:6] inside {10'h001, 10'h3ff});
                busy = acc && !bc && (c[29] || full);
                return (acc && !busy) ? n : 0;
            end
            PKT_ISO: return (c[23] && c[28]) ? n : 0;
            PKT_CYCLE_START: return c[27] ? n : 0;
            PKT_SELF_ID: return c[30] ? n + 1 : 0;
            default: return c[30] ? 1 : 0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1;
        @(posedge clock_i);
        wr_i <= 0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1;
        @(posedge clock_i);
        rd_i <= 0;
        #1 d = rd_data_o;
    endtask

    // one packet, then compare fifo words, busy acks and self-id status
    task automatic send(input pkt_kind_t k, input logic [15:0] d, input int n, input logic bad);
        logic [31:0] q;
        logic [31:0] q0;
        logic busy;
        int e;
        e = exp_store(ctrl, k, d, n, exp_w >= 8, busy);
        @(posedge clock_i);
        rx_start_i <= 1;
        rx_kind_i <= k;
        rx_dest_id_i <= d;
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            rx_start_i <= 0;
            q = (i % 2 == 1 && k == PKT_SELF_ID) ? ~q ^ {31'h0, bad} : $random(seed);
            if (i == 0) q0 = q;
            rx_quad_valid_i <= 1;
            rx_quad_i <= q;
            rx_end_i <= i == n - 1;
        end
        @(posedge clock_i);
        rx_quad_valid_i <= 0;
        rx_end_i <= 0;
        repeat (3) @(posedge clock_i);
        #1;
        exp_w += e;
        exp_b += busy;
        chk(words, exp_w);
        chk(busys, exp_b);
        if (k == PKT_SELF_ID && e > 0) chk(last, bad ? 32'hd : 32'h1);
        if (k != PKT_SELF_ID && e > 0) chk(last, e == 1 ? q0 : q);
    endtask

    task automatic drain;
        @(posedge clock_i);
        fifo_clear <= 1;
        @(posedge clock_i);
        fifo_clear <= 0;
        exp_w = 0;
    endtask

    // cut a hang short
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1;
        rd(8'h08, r);
        chk(r, 32'h0);
        rd(8'h04, r);
        chk(r, 32'h0);
        // random writes, unmapped writes ignored
        repeat (6) begin
            ctrl = $random(seed);
            wr(8'h08, ctrl);
            wr(8'h0c, ~ctrl);
            rd(8'h08, r);
            chk(r, ctrl & 32'hff800000);
        end
        // bus reset landing on a write clears both async enables
        @(posedge clock_i);
        wr_i <= 1;
        addr_i <= 8'h08;
        wr_data_i <= 32'hffffffff;
        bus_reset_i <= 1;
        async_tx_req_i <= 1;
        @(posedge clock_i);
        wr_i <= 0;
        bus_reset_i <= 0;
        rd(8'h08, r);
        chk(r, 32'hf9800000);
        // arbitration gating for every enable pair
        for (int e = 0; e < 4; e++) begin
            wr(8'h08, {5'h0, e[1], 1'b0, e[0], 24'h0});
            iso_tx_req_i <= 1;
            repeat (2) @(posedge clock_i);
            #1;
            chk(async_arb_req_o, e[1]);
            chk(iso_arb_req_o, e[0]);
        end
        // corners: fill the fifo, then busy by fullness and by force
        ctrl = 32'h92800000;
        wr(8'h08, ctrl);
        send(PKT_ISO, 16'hffff, 4, 0);
        send(PKT_ISO, 16'hffff, 4, 0);
        send(PKT_ASYNC, NODE, 2, 0);
        send(PKT_ASYNC, 16'hffff, 2, 0);
        drain;
        ctrl = 32'hb2800000;
        wr(8'h08, ctrl);
        send(PKT_ASYNC, NODE, 2, 0);
        send(PKT_ASYNC, 16'hffff, 2, 0);
        // random traffic under random control values
        for (int i = 0; i < 60; i++) begin
            if (i % 6 == 0) begin
                ctrl = $random(seed) & 32'hff800000;
                wr(8'h08, ctrl);
            end
            if (exp_w >= 8 && $random(seed) % 2 != 0) drain;
            send(pkt_kind_t'({$random(seed)} % 6), dests[{$random(seed)} % 4],
                2 + 2 * ({$random(seed)} % 2), $random(seed) % 2 != 0);
        end
        // reset in mid-run brings a written register back to zero
        wr(8'h08, 32'hffffffff);
        @(posedge clock_i);
        rst_n_i <= 0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1;
        rd(8'h08, r);
        chk(r, 32'h0);
        tally_and_finish;
    end
endmodule
